/* File: src/iolc_pkg.sv */
// Purpose: Constants and carriers for the parallel I/O line controller
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes: Offsets are byte addresses
package iolc_pkg;
	localparam int IOLC_LINES = 32;
	localparam int IOLC_AW = 8;
	localparam logic [7:0] IOLC_LINE_OWN_SET = 8'h00;
	localparam logic [7:0] IOLC_LINE_OWN_CLEAR = 8'h04;
	localparam logic [7:0] IOLC_LINE_OWN_STATE = 8'h08;
	localparam logic [7:0] IOLC_DRIVE_ON_SET = 8'h10;
	localparam logic [7:0] IOLC_DRIVE_OFF_SET = 8'h14;
	localparam logic [7:0] IOLC_DRIVE_STATE = 8'h18;
	localparam logic [7:0] IOLC_LEVEL_HIGH_SET = 8'h30;
	localparam logic [7:0] IOLC_LEVEL_LOW_SET = 8'h34;
	localparam logic [7:0] IOLC_LEVEL_OUT_STATE = 8'h38;
	localparam logic [7:0] IOLC_PIN_LEVEL = 8'h3C;
	localparam logic [7:0] IOLC_PULLUP_OFF_SET = 8'h60;
	localparam logic [7:0] IOLC_PULLUP_ON_SET = 8'h64;
	localparam logic [7:0] IOLC_PULLUP_OFF_STATE = 8'h68;
	localparam logic [7:0] IOLC_FUNC_A_PICK = 8'h70;
	localparam logic [7:0] IOLC_FUNC_B_PICK = 8'h74;
	localparam logic [7:0] IOLC_FUNC_AB_STATE = 8'h78;
	localparam logic [7:0] IOLC_DIRECT_MASK_SET = 8'hA0;
	localparam logic [7:0] IOLC_DIRECT_MASK_CLEAR = 8'hA4;
	localparam logic [7:0] IOLC_DIRECT_MASK_STATE = 8'hA8;
	localparam logic [31:0] IOLC_PULLUP_RST = 32'h0000_0000;
	localparam logic [31:0] IOLC_FUNC_RST = 32'h0000_0000;
	localparam logic [31:0] IOLC_MASK_RST = 32'h0000_0000;
	localparam logic [31:0] IOLC_DRIVE_RST = 32'h0000_0000;
	localparam logic [31:0] IOLC_LEVEL_RST = 32'h0000_0000;
	localparam logic [1:0] IOLC_RESP_OKAY = 2'b00;
	localparam logic [1:0] IOLC_RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic [31:0] oe;
		logic [31:0] level;
	} iolc_drive_s;
endpackage : iolc_pkg

/* File: src/iolc_top.sv */
// Purpose: Parallel I/O line controller with AXI4-Lite register slave
// Assumes: Pins sampled synchronous to aclk; clk_en_i models the gated clock
// Notes: Contract list below
// Contract
// - Up to 32 lines, same bit everywhere
// - Pull-up on clears, off sets status
// - Pull-up writes act regardless of ownership
// - Pull-up status resets to zero
// - Ownership set/clear drives ownership status
// - Unmultiplexed lines: ownership fixed at one
// - Ownership reset value per-line parameter
// - Pick A clears, pick B sets select
// - Select steers output; inputs see pin
// - Function select resets to zero
// - Peripheral-owned line driven by selected peripheral
// - Drive on/off sets/clears drive status
// - Drive and level writes work when peripheral-owned
// - Level high/low set drives output level
// - Direct level write only touches masked bits
// - Mask set/clear updates mask status
// - Mask status resets to zero
// - Config writes need no peripheral clock
// - Pin sampling only while clock enabled
// - Peripheral clock enable starts disabled; here clk_en_i is an input the controller does not reset
// - Absent lines ignore writes, read zero
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module iolc_top
	import iolc_pkg::*;
#(
	parameter logic [31:0] LINE_PRESENT = 32'hFFFF_FFFF,
	parameter logic [31:0] LINE_MUXED = 32'hFFFF_FFFF,
	parameter logic [31:0] OWN_RST = 32'hFFFF_FFFF
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [IOLC_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [IOLC_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Power manager clock gate
	input wire logic clk_en_i,
	// Peripheral functions
	input wire logic [31:0] periph_a_oe,
	input wire logic [31:0] periph_a_out,
	input wire logic [31:0] periph_b_oe,
	input wire logic [31:0] periph_b_out,
	output logic [31:0] periph_in,
	// Pads
	input wire logic [31:0] pad_in,
	output logic [31:0] pad_out,
	output logic [31:0] pad_oe,
	output logic [31:0] pad_pullup_en
);
	localparam logic [31:0] OWN_FIXED = LINE_PRESENT & ~LINE_MUXED;

	logic [31:0] pullup_off_q;
	logic [31:0] own_q;
	logic [31:0] func_b_q;
	logic [31:0] drive_q;
	logic [31:0] level_q;
	logic [31:0] mask_q;
	logic [31:0] pin_q;
	logic [31:0] own_state;
	logic aw_held_q;
	logic w_held_q;
	logic [IOLC_AW-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_fire;
	logic [31:0] wmask;
	logic [31:0] wval;
	logic wr_hit;
	logic rd_hit;
	logic [31:0] rd_val;
	iolc_drive_s drv_d;

	// Write address and data captured independently
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready = !w_held_q && !s_axi_bvalid;
	assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			awaddr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_q <= 1'b0;
		end
	end

	// Byte strobes and absent lines gate the written ones
	always_comb begin
		wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
		wmask = wmask & LINE_PRESENT;
		wval = wdata_q & wmask;
	end

	always_comb begin
		case ({awaddr_q[IOLC_AW-1:2], 2'b00})
			IOLC_LINE_OWN_SET, IOLC_LINE_OWN_CLEAR, IOLC_DRIVE_ON_SET,
			IOLC_DRIVE_OFF_SET, IOLC_LEVEL_HIGH_SET, IOLC_LEVEL_LOW_SET,
			IOLC_LEVEL_OUT_STATE, IOLC_PULLUP_OFF_SET, IOLC_PULLUP_ON_SET,
			IOLC_FUNC_A_PICK, IOLC_FUNC_B_PICK, IOLC_DIRECT_MASK_SET,
			IOLC_DIRECT_MASK_CLEAR: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= IOLC_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? IOLC_RESP_OKAY : IOLC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Configuration registers; none depends on clk_en_i
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pullup_off_q <= IOLC_PULLUP_RST;
		end else if (wr_fire && awaddr_q == IOLC_PULLUP_OFF_SET) begin
			pullup_off_q <= pullup_off_q | wval;
		end else if (wr_fire && awaddr_q == IOLC_PULLUP_ON_SET) begin
			pullup_off_q <= pullup_off_q & ~wval;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			own_q <= OWN_RST & LINE_PRESENT;
		end else if (wr_fire && awaddr_q == IOLC_LINE_OWN_SET) begin
			own_q <= own_q | (wval & LINE_MUXED);
		end else if (wr_fire && awaddr_q == IOLC_LINE_OWN_CLEAR) begin
			own_q <= own_q & ~(wval & LINE_MUXED);
		end
	end
	assign own_state = (own_q & LINE_MUXED & LINE_PRESENT) | OWN_FIXED;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			func_b_q <= IOLC_FUNC_RST;
		end else if (wr_fire && awaddr_q == IOLC_FUNC_A_PICK) begin
			func_b_q <= func_b_q & ~wval;
		end else if (wr_fire && awaddr_q == IOLC_FUNC_B_PICK) begin
			func_b_q <= func_b_q | wval;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drive_q <= IOLC_DRIVE_RST;
		end else if (wr_fire && awaddr_q == IOLC_DRIVE_ON_SET) begin
			drive_q <= drive_q | wval;
		end else if (wr_fire && awaddr_q == IOLC_DRIVE_OFF_SET) begin
			drive_q <= drive_q & ~wval;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_q <= IOLC_LEVEL_RST;
		end else if (wr_fire && awaddr_q == IOLC_LEVEL_HIGH_SET) begin
			level_q <= level_q | wval;
		end else if (wr_fire && awaddr_q == IOLC_LEVEL_LOW_SET) begin
			level_q <= level_q & ~wval;
		end else if (wr_fire && awaddr_q == IOLC_LEVEL_OUT_STATE) begin
			level_q <= (level_q & ~(mask_q & wmask)) | (wdata_q & mask_q & wmask);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_q <= IOLC_MASK_RST;
		end else if (wr_fire && awaddr_q == IOLC_DIRECT_MASK_SET) begin
			mask_q <= mask_q | wval;
		end else if (wr_fire && awaddr_q == IOLC_DIRECT_MASK_CLEAR) begin
			mask_q <= mask_q & ~wval;
		end
	end

	// Pin level holds its last sample while the clock is gated
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_q <= '0;
		end else if (clk_en_i) begin
			pin_q <= pad_in & LINE_PRESENT;
		end
	end

	// Per-line output mux
	generate
		for (genvar i = 0; i < IOLC_LINES; i++) begin : g_line
			always_comb begin
				if (own_state[i]) begin
					drv_d.oe[i] = drive_q[i];
					drv_d.level[i] = level_q[i];
				end else if (func_b_q[i]) begin
					drv_d.oe[i] = periph_b_oe[i];
					drv_d.level[i] = periph_b_out[i];
				end else begin
					drv_d.oe[i] = periph_a_oe[i];
					drv_d.level[i] = periph_a_out[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pad_oe <= '0;
			pad_out <= '0;
		end else begin
			pad_oe <= drv_d.oe & LINE_PRESENT;
			pad_out <= drv_d.level & LINE_PRESENT;
		end
	end
	assign pad_pullup_en = ~pullup_off_q & LINE_PRESENT;
	assign periph_in = pad_in;

	// Read channel
	always_comb begin
		rd_hit = 1'b1;
		case ({s_axi_araddr[IOLC_AW-1:2], 2'b00})
			IOLC_LINE_OWN_STATE: rd_val = own_state;
			IOLC_DRIVE_STATE: rd_val = drive_q;
			IOLC_LEVEL_OUT_STATE: rd_val = level_q;
			IOLC_PIN_LEVEL: rd_val = pin_q;
			IOLC_PULLUP_OFF_STATE: rd_val = pullup_off_q;
			IOLC_FUNC_AB_STATE: rd_val = func_b_q;
			IOLC_DIRECT_MASK_STATE: rd_val = mask_q;
			default: begin
				rd_val = '0;
				rd_hit = 1'b0;
			end
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= IOLC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val & LINE_PRESENT;
			s_axi_rresp <= rd_hit ? IOLC_RESP_OKAY : IOLC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Assertions
	sequence wr_to(logic [7:0] a);
		wr_fire && awaddr_q == a;
	endsequence

	pullup_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_to(IOLC_PULLUP_ON_SET) |=> (pullup_off_q & $past(wval)) == 32'h0)
		else $error("pull-up enable write left status set");
	pullup_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_to(IOLC_PULLUP_OFF_SET) |=> (pullup_off_q & $past(wval)) == $past(wval))
		else $error("pull-up disable write not applied");
	own_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_to(IOLC_LINE_OWN_SET) |=> (own_state & $past(wval)) == $past(wval))
		else $error("ownership set not applied");
	own_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_to(IOLC_LINE_OWN_CLEAR) |=> (own_state & $past(wval) & LINE_MUXED) == 32'h0)
		else $error("ownership clear not applied");
	own_fixed_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(own_state & OWN_FIXED) == OWN_FIXED)
		else $error("unmultiplexed line lost ownership");
	own_reset_a: assert property (@(posedge aclk)
		!aresetn |=> own_state == ((OWN_RST & LINE_MUXED & LINE_PRESENT) | OWN_FIXED))
		else $error("ownership reset value wrong");
	reset_vals_a: assert property (@(posedge aclk)
		!aresetn |=> pullup_off_q == IOLC_PULLUP_RST && func_b_q == IOLC_FUNC_RST
			&& mask_q == IOLC_MASK_RST)
		else $error("status register reset value wrong");
	func_a_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_to(IOLC_FUNC_A_PICK) |=> (func_b_q & $past(wval)) == 32'h0)
		else $error("function A pick not applied");
	func_b_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_to(IOLC_FUNC_B_PICK) |=> (func_b_q & $past(wval)) == $past(wval))
		else $error("function B pick not applied");
	func_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && awaddr_q != IOLC_FUNC_A_PICK && awaddr_q != IOLC_FUNC_B_PICK
			|=> $stable(func_b_q))
		else $error("select changed by another write");
	periph_drv_a: assert property (@(posedge aclk) disable iff (!aresetn)
		aresetn && !own_state[0] && !func_b_q[0] && LINE_PRESENT[0]
			|=> pad_oe[0] == $past(periph_a_oe[0]))
		else $error("peripheral A drive not routed");
	periph_b_drv_a: assert property (@(posedge aclk) disable iff (!aresetn)
		aresetn && !own_state[6] && func_b_q[6] && LINE_PRESENT[6]
			|=> pad_oe[6] == $past(periph_b_oe[6]))
		else $error("peripheral B drive not routed");
	ctrl_drv_a: assert property (@(posedge aclk) disable iff (!aresetn)
		aresetn && own_state[0] && LINE_PRESENT[0] |=> pad_out[0] == $past(level_q[0]))
		else $error("controller level not driven");
	drive_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_to(IOLC_DRIVE_ON_SET) |=> (drive_q & $past(wval)) == $past(wval))
		else $error("drive enable not set");
	drive_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_to(IOLC_DRIVE_OFF_SET) |=> (drive_q & $past(wval)) == 32'h0)
		else $error("drive disable not applied");
	level_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_to(IOLC_LEVEL_HIGH_SET) |=> (level_q & $past(wval)) == $past(wval))
		else $error("level set not applied");
	level_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_to(IOLC_LEVEL_LOW_SET) |=> (level_q & $past(wval)) == 32'h0)
		else $error("level clear not applied");
	set_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_to(IOLC_LEVEL_HIGH_SET) |=> (level_q & ~$past(wval)) == ($past(level_q) & ~$past(wval)))
		else $error("zero bit of set write changed a line");
	direct_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_to(IOLC_LEVEL_OUT_STATE)
			|=> (level_q & ~$past(mask_q)) == ($past(level_q) & ~$past(mask_q)))
		else $error("direct write touched unmasked bit");
	direct_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_to(IOLC_LEVEL_OUT_STATE) |=> (level_q & $past(mask_q) & $past(wmask))
			== ($past(wdata_q) & $past(mask_q) & $past(wmask)))
		else $error("direct write missed masked bit");
	mask_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_to(IOLC_DIRECT_MASK_SET) |=> (mask_q & $past(wval)) == $past(wval))
		else $error("mask set not applied");
	mask_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_to(IOLC_DIRECT_MASK_CLEAR) |=> (mask_q & $past(wval)) == 32'h0)
		else $error("mask clear not applied");
	pin_sample_a: assert property (@(posedge aclk) disable iff (!aresetn)
		aresetn && clk_en_i |=> pin_q == ($past(pad_in) & LINE_PRESENT))
		else $error("pins not sampled while clock enabled");
	pin_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!clk_en_i |=> $stable(pin_q))
		else $error("pins sampled while clock gated");
	absent_reg_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire |=> ((pullup_off_q | own_q | func_b_q | drive_q | level_q | mask_q)
			& ~LINE_PRESENT) == 32'h0)
		else $error("absent line took a write");
	absent_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> (s_axi_rdata & ~LINE_PRESENT) == 32'h0)
		else $error("absent line read nonzero");
endmodule : iolc_top
`default_nettype wire

/* File: sim/iolc_far_model.sv */
// Purpose: Peripherals A and B plus the pads beyond the controller
// Assumes: Peripherals drive fixed patterns
// Notes: Undriven pad reads the pull-up, else the outside level
`timescale 1ns/1ps
`default_nettype none
module iolc_far_model
	import iolc_pkg::*;
#(
	parameter logic [31:0] A_OE = 32'hAAAA_AAAA,
	parameter logic [31:0] A_OUT = 32'hCCCC_CCCC,
	parameter logic [31:0] B_OE = 32'h5555_5555,
	parameter logic [31:0] B_OUT = 32'hF0F0_F0F0,
	parameter logic [31:0] EXT_LVL = 32'h0000_0000
) (
	// Pads from controller
	input wire logic [31:0] pad_out,
	input wire logic [31:0] pad_oe,
	input wire logic [31:0] pad_pullup_en,
	// Peripheral drive and pad level
	output logic [31:0] periph_a_oe,
	output logic [31:0] periph_a_out,
	output logic [31:0] periph_b_oe,
	output logic [31:0] periph_b_out,
	output logic [31:0] pad_in
);
	assign periph_a_oe = A_OE;
	assign periph_a_out = A_OUT;
	assign periph_b_oe = B_OE;
	assign periph_b_out = B_OUT;
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & (pad_pullup_en | EXT_LVL));
endmodule : iolc_far_model
`default_nettype wire

/* File: sim/parallel_io_line_controller_test.sv */
// Purpose: Self-checking bench for the I/O line controller
// Assumes: Line 30 unmultiplexed, line 31 absent, line 0 resets peripheral-owned
// Notes: Table rows run in order and build on each other
`timescale 1ns/1ps
`default_nettype none
module parallel_io_line_controller_test
	import iolc_pkg::*;
;
	localparam logic [31:0] PRES = 32'h7FFF_FFFF;
	localparam logic [31:0] MUX = 32'h3FFF_FFFF;
	localparam logic [31:0] ORST = 32'hFFFF_FFFE;
	localparam logic [31:0] A_OE = 32'hAAAA_AAAA;
	localparam logic [31:0] A_OUT = 32'hCCCC_CCCC;
	localparam logic [31:0] B_OE = 32'h5555_5555;
	localparam logic [31:0] B_OUT = 32'hF0F0_F0F0;
	localparam logic [31:0] OWN_E = 32'h4000_000F;
	localparam logic [31:0] DRV_E = 32'h0000_00F3;
	localparam logic [31:0] LVL_E = 32'h0000_FF78;
	localparam logic [31:0] AB_E = 32'h0000_00C0;
	localparam logic [31:0] OE_E = ((OWN_E & DRV_E)
		| (~OWN_E & ((AB_E & B_OE) | (~AB_E & A_OE)))) & PRES;
	localparam logic [31:0] OUT_E = (OWN_E & LVL_E) | (~OWN_E & ((AB_E & B_OUT) | (~AB_E & A_OUT)));
	typedef struct packed {
		logic [7:0] wa;
		logic [31:0] wd;
		logic [7:0] ra;
		logic [31:0] ex;
	} iolc_row_s;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic clk_en = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, a_oe, a_out, b_oe, b_out, p_in, pad_in, pad_out, pad_oe, pu_en;
	int num_errors = 0;
	int n_compared = 0;
	iolc_row_s rows [14] = '{
		'{IOLC_LINE_OWN_CLEAR, 32'hFFFF_FFFF, IOLC_LINE_OWN_STATE, 32'h4000_0000},
		'{IOLC_LINE_OWN_SET, 32'h0000_000F, IOLC_LINE_OWN_STATE, 32'h4000_000F},
		'{IOLC_FUNC_B_PICK, 32'h0000_00F0, IOLC_FUNC_AB_STATE, 32'h0000_00F0},
		'{IOLC_FUNC_A_PICK, 32'h0000_0030, IOLC_FUNC_AB_STATE, 32'h0000_00C0},
		'{IOLC_PULLUP_OFF_SET, 32'hFFFF_FFFF, IOLC_PULLUP_OFF_STATE, 32'h7FFF_FFFF},
		'{IOLC_PULLUP_ON_SET, 32'h0000_FFFF, IOLC_PULLUP_OFF_STATE, 32'h7FFF_0000},
		'{IOLC_DRIVE_ON_SET, 32'h0000_00FF, IOLC_DRIVE_STATE, 32'h0000_00FF},
		'{IOLC_DRIVE_OFF_SET, 32'h0000_000C, IOLC_DRIVE_STATE, 32'h0000_00F3},
		'{IOLC_LEVEL_HIGH_SET, 32'h0000_FFFF, IOLC_LEVEL_OUT_STATE, 32'h0000_FFFF},
		'{IOLC_LEVEL_LOW_SET, 32'h0000_00F0, IOLC_LEVEL_OUT_STATE, 32'h0000_FF0F},
		'{IOLC_LEVEL_OUT_STATE, 32'h1234_5678, IOLC_LEVEL_OUT_STATE, 32'h0000_FF0F},
		'{IOLC_DIRECT_MASK_SET, 32'h0000_00FF, IOLC_DIRECT_MASK_STATE, 32'h0000_00FF},
		'{IOLC_LEVEL_OUT_STATE, 32'h1234_5678, IOLC_LEVEL_OUT_STATE, 32'h0000_FF78},
		'{IOLC_DIRECT_MASK_CLEAR, 32'h0000_000F, IOLC_DIRECT_MASK_STATE, 32'h0000_00F0}
	};
	iolc_top #(.LINE_PRESENT(PRES), .LINE_MUXED(MUX), .OWN_RST(ORST)) i_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.clk_en_i(clk_en), .periph_a_oe(a_oe), .periph_a_out(a_out), .periph_b_oe(b_oe),
		.periph_b_out(b_out), .periph_in(p_in), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe(pad_oe), .pad_pullup_en(pu_en)
	);
	iolc_far_model #(.A_OE(A_OE), .A_OUT(A_OUT), .B_OE(B_OE), .B_OUT(B_OUT)) i_far (
		.pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pu_en), .periph_a_oe(a_oe),
		.periph_a_out(a_out), .periph_b_oe(b_oe), .periph_b_out(b_out), .pad_in(pad_in)
	);
	initial forever #12.5 aclk = ~aclk;
	task close_out;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task chkr(input string n, input logic [1:0] e, input logic [1:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chkr
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		int i;
		logic ta, tw, tb;
		tb = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50 && !tb; i++) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
		end
		if (!tb) begin
			chk("write wait", 32'h0, 32'h1);
			close_out();
		end
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		logic ta, tb;
		tb = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50 && !tb; i++) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tb = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tb) rready <= 1'b0;
		end
		if (!tb) begin
			chk("read wait", 32'h0, 32'h1);
			close_out();
		end
	endtask : rd
	task rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk("rdata", e, d);
		chkr("rresp", IOLC_RESP_OKAY, r);
	endtask : rchk
	initial begin
		logic [31:0] d, pin;
		logic [1:0] r;
		int k;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(IOLC_LINE_OWN_STATE, (ORST | ~MUX) & PRES);
		rchk(IOLC_FUNC_AB_STATE, 32'h0);
		rchk(IOLC_PULLUP_OFF_STATE, 32'h0);
		rchk(IOLC_DIRECT_MASK_STATE, 32'h0);
		for (k = 0; k < 14; k++) begin
			wr(rows[k].wa, rows[k].wd, 4'hF, r);
			chkr("bresp", IOLC_RESP_OKAY, r);
			rchk(rows[k].ra, rows[k].ex);
		end
		repeat (3) @(posedge aclk);
		chk("pad_oe", OE_E, pad_oe);
		chk("pad_out", OUT_E & OE_E, pad_out & pad_oe);
		chk("periph_in", pad_in, p_in);
		chk("pad_pullup_en", 32'h0000_FFFF, pu_en & PRES);
		clk_en <= 1'b1;
		repeat (4) @(posedge aclk);
		pin = pad_in;
		rchk(IOLC_PIN_LEVEL, pin & PRES);
		clk_en <= 1'b0;
		wr(IOLC_LEVEL_HIGH_SET, 32'h0000_0003, 4'hF, r);
		rchk(IOLC_LEVEL_OUT_STATE, 32'h0000_FF7B);
		repeat (3) @(posedge aclk);
		chk("pad_out", 32'h0000_0003, pad_out & 32'h0000_0003);
		rchk(IOLC_PIN_LEVEL, pin & PRES);
		wr(IOLC_DRIVE_STATE, 32'h0000_0001, 4'hF, r);
		chkr("bresp", IOLC_RESP_SLVERR, r);
		rchk(IOLC_DRIVE_STATE, DRV_E);
		wr(IOLC_DRIVE_ON_SET, 32'hFFFF_FFFF, 4'h2, r);
		chkr("bresp", IOLC_RESP_OKAY, r);
		rchk(IOLC_DRIVE_STATE, DRV_E | 32'h0000_FF00);
		rd(8'hFC, d, r);
		chkr("rresp", IOLC_RESP_SLVERR, r);
		chk("rdata", 32'h0, d);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(IOLC_DIRECT_MASK_STATE, 32'h0);
		rchk(IOLC_PULLUP_OFF_STATE, 32'h0);
		rchk(IOLC_LINE_OWN_STATE, (ORST | ~MUX) & PRES);
		rchk(IOLC_FUNC_AB_STATE, 32'h0);
		close_out();
	end
endmodule : parallel_io_line_controller_test
`default_nettype wire
